// file: rtl/pac_autoneg.sv
// Autoneg control and status of a 10/100 PHY, APB register slave.
// Assumes a page decoder on pclk and analog link detectors on raw pins.
// Contract
// - Rank modes: 100 full, 100 half, 10 full, 10 half lowest.
// - Start negotiation after reset and again on link validity change.
// - While enabled, send advertised abilities in link pulse bursts. Code: bursts only in the ability state, none during break or once complete.
// - Advert bits 8:5 and enable bit 12 reset from power-up straps.
// - Status speed and duplex valid only when complete or disabled.
// - Compare partner and own abilities, pick best common mode.
// - Status register shows complete bit 4, duplex 2, speed 1.
// - Disabled: control bit 13 picks speed, bit 8 duplex.
// - Enabled: speed and duplex control bits are ignored.
// - Basic status ability bits read constant ones, T4 reads zero.
// - Advert defaults to all abilities; software may clear some. Code: bits 8:5 default to the strap_adv value.
// - Any ability combination is accepted and advertised exactly.
// - Partner register captures base page and each next page.
// - Parallel detect loads 0081h for 100, 0021h for 10.
// - Expansion: fault 4, partner NP 3, local NP 2, page 1, able 0.
// - Control bit 9 restarts; negotiation resumes on link loss.
// - Restart halts pulses for break timer, then resumes bursts.
// - Parallel detect sets fault when both 100 and 10 links are good.
`timescale 1ns/1ns
`include "pac_defs.svh"
module pac_autoneg
  import pac_pkg::*;
#(
  parameter int BREAK_CYCLES = `PAC_BREAK_MS * `PAC_CLK_KHZ
) (
  input  wire logic        pclk,         // APB clock, 125 MHz
  input  wire logic        presetn,      // Async reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB write
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error, unmapped address
  input  wire logic        strap_an_en,  // Power-up autoneg enable
  input  wire logic [3:0]  strap_adv,    // Power-up abilities 8:5
  input  wire logic        link100_raw,  // 100 Mb/s link detect pin
  input  wire logic        link10_raw,   // 10 Mb/s link detect pin
  input  wire logic        flp_seen,     // Partner bursts present
  input  wire logic        page_in,      // Code word received pulse
  input  wire logic [15:0] page_word,    // Received code word
  output logic             tx_flp_en,    // Send bursts
  output logic             tx_halt,      // Stop data and pulses
  output logic      [15:0] tx_code_word, // Word to send
  output pac_mode_t        mode,         // Resolved operating mode
  output logic             an_complete   // Negotiation complete
);
  // Break state needs two cycles to load and count down
  if (BREAK_CYCLES < 2) begin : g_break_check
    $error("BREAK_CYCLES too small");
  end

  // ==========================================
  // Resolution and decode helpers
  function automatic pac_mode_t resolve(input logic [3:0] a,
                                        input logic [3:0] b);
    logic [3:0] c;
    c = a & b;
    // No ties: the bit order of the field is the priority order
    resolve.ok       = |c;
    resolve.speed100 = c[`PAC_AB_100F] | c[`PAC_AB_100H];
    resolve.full     = c[`PAC_AB_100F] |
                       (~c[`PAC_AB_100H] & c[`PAC_AB_10F]);
  endfunction : resolve

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == `PAC_OFF_BMC || a == `PAC_OFF_BMS ||
             a == `PAC_OFF_ADV || a == `PAC_OFF_LPA ||
             a == `PAC_OFF_EXP || a == `PAC_OFF_STS;
  endfunction : mapped

  pac_regs_t   s;
  pac_regs_t   next_s;
  logic        link_ok;
  logic        an_on;
  logic [15:0] bms;
  logic [15:0] exp_r;
  logic [15:0] sts;
  logic [15:0] rd_val;
  logic        wr;
  logic        rd;
  logic        pd_one;
  logic        pd_two;
  logic        pd_hit;
  pac_mode_t   res;
  logic [3:0]  pg_ab;

  assign an_on   = s.bmc[`PAC_BMC_ANEN];
  // Judged on the speed in use, so a link at the other speed reads down
  assign link_ok = s.spd100 ? s.l100 : s.l10;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign pd_one  = ~flp_seen & ~s.base_got & (s.l100 ^ s.l10);
  assign pd_two  = ~flp_seen & ~s.base_got & s.l100 & s.l10;
  assign pd_hit  = (s.st == PAC_ABILITY) & ~page_in & pd_two;
  assign pg_ab   = page_word[`PAC_AB_HI:`PAC_AB_LO];
  // Base page abilities hold once captured; next pages carry none
  assign res     = resolve(s.adv[`PAC_AB_HI:`PAC_AB_LO],
                           s.base_got ? s.lp_ab : pg_ab);

  // ==========================================
  // Status views
  always_comb begin
    bms = `PAC_BMS_CONST;
    bms[5] = s.complete;
    bms[4] = s.lp_rf;
    bms[2] = link_ok;
    exp_r = 16'h0004;
    exp_r[4] = s.pd_fault;
    exp_r[3] = s.lp_np;
    exp_r[1] = s.pg_rcvd;
    exp_r[0] = s.lp_an;
    sts = 16'h0000;
    sts[4] = s.complete;
    sts[3] = s.bmc[`PAC_BMC_LOOP];
    sts[0] = link_ok;
    if (s.complete || !an_on) begin
      sts[2] = s.full;
      sts[1] = s.spd100;
    end
  end

  always_comb begin
    unique case (paddr)
      `PAC_OFF_BMC: rd_val = s.bmc;
      `PAC_OFF_BMS: rd_val = bms;
      `PAC_OFF_ADV: rd_val = s.adv;
      `PAC_OFF_LPA: rd_val = s.lpa;
      `PAC_OFF_EXP: rd_val = exp_r;
      `PAC_OFF_STS: rd_val = sts;
      default:      rd_val = 16'h0000;
    endcase
  end

  // ==========================================
  // Next state
  always_comb begin
    next_s = s;
    // Link pins: a change counts once stages two and three agree
    next_s.s100 = {s.s100[1:0], link100_raw};
    next_s.s10  = {s.s10[1:0], link10_raw};
    if (s.s100[1] == s.s100[2]) next_s.l100 = s.s100[2];
    if (s.s10[1] == s.s10[2]) next_s.l10 = s.s10[2];
    // Captured in setup so the access cycle needs no wait state
    if (psel && !penable) begin
      next_s.prdata = {16'h0000, rd_val};
      next_s.slverr = ~mapped(paddr);
    end
    unique case (s.st)
      // Straps are sampled once, on the first edge out of reset
      PAC_STRAP: begin
        next_s.bmc[`PAC_BMC_ANEN] = strap_an_en;
        next_s.adv[`PAC_AB_HI:`PAC_AB_LO] = strap_adv;
        next_s.st = strap_an_en ? PAC_ABILITY : PAC_FORCED;
      end
      PAC_FORCED: begin
        next_s.spd100 = s.bmc[`PAC_BMC_SPD];
        next_s.full   = s.bmc[`PAC_BMC_DUP];
      end
      // Counting down to one keeps the halt exactly BREAK_CYCLES long
      PAC_BREAK: begin
        next_s.timer = s.timer - 32'h00000001;
        if (s.timer == 32'h00000001) next_s.st = PAC_ABILITY;
      end
      PAC_ABILITY: begin
        if (page_in) begin
          next_s.lpa     = page_word;
          next_s.pg_rcvd = 1'b1;
          next_s.lp_an   = 1'b1;
          if (!s.base_got) begin
            next_s.base_got = 1'b1;
            next_s.lp_ab    = pg_ab;
            next_s.lp_np    = page_word[`PAC_PG_NP];
            next_s.lp_rf    = page_word[`PAC_PG_RF];
          end
          if (!page_word[`PAC_PG_NP]) begin
            if (res.ok) begin
              next_s.spd100   = res.speed100;
              next_s.full     = res.full;
              next_s.complete = 1'b1;
              next_s.st       = PAC_DONE;
            end else begin
              next_s.base_got = 1'b0;
            end
          end
        end else if (pd_one) begin
          next_s.lpa = s.l100 ? `PAC_LPA_PD100 : `PAC_LPA_PD10;
          next_s.lp_an    = 1'b0;
          next_s.spd100   = s.l100;
          next_s.full     = 1'b0;
          next_s.complete = 1'b1;
          next_s.st       = PAC_DONE;
        end else if (pd_two) begin
          next_s.pd_fault = 1'b1;
        end
      end
      // No break timer here: the partner already sees the link drop
      PAC_DONE: begin
        if (!link_ok) begin
          next_s.st       = PAC_ABILITY;
          next_s.complete = 1'b0;
          next_s.base_got = 1'b0;
        end
      end
    endcase
    // Reading expansion clears the page flag; a new page still wins
    if (rd && paddr == `PAC_OFF_EXP && !(page_in &&
        s.st == PAC_ABILITY)) next_s.pg_rcvd = 1'b0;
    if (wr && s.st != PAC_STRAP) begin
      if (paddr == `PAC_OFF_ADV)
        next_s.adv = (pwdata[15:0] & `PAC_ADV_WMASK) |
                     (`PAC_ADV_RESET & ~`PAC_ADV_WMASK);
      if (paddr == `PAC_OFF_BMC) begin
        next_s.bmc = pwdata[15:0] & `PAC_BMC_WMASK;
        next_s.bmc[`PAC_BMC_RST] = 1'b0;
        if (!pwdata[`PAC_BMC_ANEN]) begin
          next_s.st       = PAC_FORCED;
          next_s.complete = 1'b0;
        end else if (!an_on) begin
          // Only a clear-then-set arms negotiation from forced mode
          next_s.st       = PAC_ABILITY;
          next_s.complete = 1'b0;
          next_s.base_got = 1'b0;
          // A fault seen in this same cycle survives the clear
          next_s.pd_fault = pd_hit;
        end else if (pwdata[`PAC_BMC_RST]) begin
          next_s.st       = PAC_BREAK;
          next_s.timer    = 32'(BREAK_CYCLES);
          next_s.complete = 1'b0;
          next_s.base_got = 1'b0;
          next_s.pd_fault = pd_hit;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.st       <= PAC_STRAP;
      s.adv      <= `PAC_ADV_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // Outputs
  assign prdata       = s.prdata;
  // Zero wait states: every access phase completes at once
  assign pready       = 1'b1;
  assign pslverr      = s.slverr;
  assign tx_flp_en    = s.st == PAC_ABILITY;
  assign tx_halt      = s.st == PAC_BREAK;
  assign tx_code_word = s.adv;
  assign mode         = {s.spd100, s.full,
                         s.complete | (s.st == PAC_FORCED)};
  assign an_complete   = s.complete;

  // ==========================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_break_halt: assert property (
    s.st == PAC_BREAK |-> tx_halt && !tx_flp_en)
    else $error("bursts during break");
  a_break_len: assert property (
    $rose(s.st == PAC_BREAK) |-> s.timer == BREAK_CYCLES)
    else $error("break timer not loaded");
  a_reset_start: assert property (
    s.st == PAC_STRAP |=> s.st == ($past(strap_an_en) ?
                                   PAC_ABILITY : PAC_FORCED))
    else $error("no start after reset");
  a_link_loss: assert property (
    s.st == PAC_DONE && !link_ok && !wr |=>
      s.st == PAC_ABILITY && !an_complete)
    else $error("no resume on link loss");
  a_restart_req: assert property (
    wr && paddr == `PAC_OFF_BMC && pwdata[`PAC_BMC_RST] &&
    pwdata[`PAC_BMC_ANEN] && an_on && s.st != PAC_STRAP |=>
      s.st == PAC_BREAK ##1 tx_halt)
    else $error("restart ignored");
  a_pd_load: assert property (
    s.st == PAC_ABILITY && !page_in && pd_one && !wr |=>
      s.lpa == ($past(s.l100) ? `PAC_LPA_PD100 : `PAC_LPA_PD10))
    else $error("parallel detect word wrong");
  a_pd_fault: assert property (
    s.st == PAC_ABILITY && !page_in && pd_two && !wr |=> s.pd_fault)
    else $error("fault not flagged");
  a_rank_top: assert property (
    s.st == PAC_ABILITY && page_in && !s.base_got && !wr &&
    !page_word[`PAC_PG_NP] && page_word[`PAC_AB_HI] &&
    s.adv[`PAC_AB_HI] |=> mode.speed100 && mode.full && an_complete)
    else $error("best mode not chosen");
  a_forced_mode: assert property (
    s.st == PAC_FORCED && !wr |=> mode.speed100 ==
      $past(s.bmc[`PAC_BMC_SPD]) && mode.full ==
      $past(s.bmc[`PAC_BMC_DUP]))
    else $error("forced mode not applied");
  a_sts_valid: assert property (
    !s.complete && an_on |-> sts[2:1] == 2'b00)
    else $error("unqualified speed shown");
  a_basic_mode_status_const: assert property (
    (bms & `PAC_BMS_CONST) == `PAC_BMS_CONST && !bms[15])
    else $error("ability bits wrong");

  a_strap_load: assert property (
    s.st == PAC_STRAP |=> an_on == $past(strap_an_en) &&
      s.adv[`PAC_AB_HI:`PAC_AB_LO] == $past(strap_adv))
    else $error("straps not loaded");
  a_page_capture: assert property (
    s.st == PAC_ABILITY && page_in |=> s.lpa == $past(page_word))
    else $error("page word not captured");
  a_page_flag: assert property (
    s.st == PAC_ABILITY && page_in |=> s.pg_rcvd)
    else $error("page flag not set");
  a_word_sent: assert property (
    tx_flp_en |-> tx_code_word == s.adv && an_on)
    else $error("bursts without advert");

  // ==========================================
  // Cover points

  c_page_done: cover property (s.st == PAC_ABILITY && page_in ##1
                               s.st == PAC_DONE);
  c_pd_done: cover property (pd_one && s.st == PAC_ABILITY ##1
                             s.st == PAC_DONE);
  c_break_end: cover property (s.st == PAC_BREAK ##1
                               s.st == PAC_ABILITY);
  c_forced_out: cover property (s.st == PAC_FORCED ##1
                                s.st == PAC_ABILITY);
  c_fault_seen: cover property (pd_hit ##1 s.pd_fault);
endmodule : pac_autoneg

// file: rtl/pac_defs.svh
// Offsets, field positions, reset values and timing for autoneg control.
// Assumes an APB byte address whose low eight bits select the register.
`ifndef PAC_DEFS_SVH
`define PAC_DEFS_SVH
// ==========================================
// Register byte offsets
`define PAC_OFF_BMC   8'h80
`define PAC_OFF_BMS   8'h84
`define PAC_OFF_ADV   8'h90
`define PAC_OFF_LPA   8'h94
`define PAC_OFF_EXP   8'h98
`define PAC_OFF_STS   8'hC0
// ==========================================
// Basic control bits
`define PAC_BMC_LOOP  14
`define PAC_BMC_SPD   13
`define PAC_BMC_ANEN  12
`define PAC_BMC_RST   9
`define PAC_BMC_DUP   8
`define PAC_BMC_WMASK 16'h7300
// ==========================================
// Ability fields
`define PAC_AB_HI     8
`define PAC_AB_LO     5
`define PAC_AB_100F   3
`define PAC_AB_100H   2
`define PAC_AB_10F    1
`define PAC_PG_NP     15
`define PAC_PG_RF     13
`define PAC_ADV_RESET 16'h01E1
`define PAC_ADV_WMASK 16'hFFE0
`define PAC_BMS_CONST 16'h7849
`define PAC_LPA_PD100 16'h0081
`define PAC_LPA_PD10  16'h0021
// ==========================================
// Timing
`define PAC_BREAK_MS  1500
`define PAC_CLK_KHZ   125000
`endif

// file: rtl/pac_pkg.sv
// Types shared by the autoneg control block.
// Assumes pac_defs.svh supplies all numeric constants.
package pac_pkg;
  typedef enum logic [2:0] {
    PAC_STRAP, PAC_FORCED, PAC_BREAK, PAC_ABILITY, PAC_DONE
  } pac_state_t;
  typedef struct packed {
    logic speed100;
    logic full;
    logic ok;
  } pac_mode_t;
  typedef struct packed {
    pac_state_t  st;
    logic [15:0] bmc;
    logic [15:0] adv;
    logic [15:0] lpa;
    logic [3:0]  lp_ab;
    logic        base_got;
    logic        lp_np;
    logic        lp_rf;
    logic        lp_an;
    logic        pg_rcvd;
    logic        pd_fault;
    logic        complete;
    logic        spd100;
    logic        full;
    logic [31:0] timer;
    logic [31:0] prdata;
    logic        slverr;
    logic [2:0]  s100;
    logic [2:0]  s10;
    logic        l100;
    logic        l10;
  } pac_regs_t;
endpackage : pac_pkg

// file: verification/pac_autoneg_test.sv
// Self-checking bench for autoneg control over APB.
// Assumes pac_partner stands in for the far end of the twisted pair.
`timescale 1ns/1ns
`include "pac_defs.svh"
module pac_autoneg_test
  import pac_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        strap_an_en, flp_seen, page_in, link100_raw, link10_raw;
  logic [3:0]  strap_adv;
  logic [15:0] page_word, tx_code_word;
  logic        tx_flp_en, tx_halt, an_complete, er;
  pac_mode_t   mode;
  int          num_errors, num_checks, cyc, n, k;

  // Short break timer keeps the restart scenario brief
  pac_autoneg #(.BREAK_CYCLES(20)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .strap_an_en(strap_an_en),
    .strap_adv(strap_adv), .link100_raw(link100_raw),
    .link10_raw(link10_raw), .flp_seen(flp_seen), .page_in(page_in),
    .page_word(page_word), .tx_flp_en(tx_flp_en), .tx_halt(tx_halt),
    .tx_code_word(tx_code_word), .mode(mode), .an_complete(an_complete));
  pac_partner lp (
    .pclk(pclk), .tx_flp_en(tx_flp_en), .flp_seen(flp_seen),
    .page_in(page_in), .page_word(page_word),
    .link100_raw(link100_raw), .link10_raw(link10_raw));

  // ==========================================
  // Clock, timeout and reporting
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // ==========================================
  // APB master and waits
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the run timeout ends a wait for ready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask : rdchk
  task automatic wait_an(input logic v);
    int t;
    t = 0;
    while (an_complete !== v && t < 100) begin
      @(posedge pclk);
      t++;
    end
    chk("an_complete", 32'(v), 32'(an_complete));
  endtask : wait_an
  task automatic pd(input logic l1, input logic l0, input logic [31:0] e,
                    input logic [2:0] m);
    lp.set_link(1'b0, l1, l0);
    wait_an(1'b1);
    rdchk("pd_lpa", `PAC_OFF_LPA, e, 32'hFFFFFFFF);
    chk("pd_mode", 32'(m), 32'(mode));
    rdchk("pd_able", `PAC_OFF_EXP, 32'h0, 32'h1);
    lp.set_link(1'b0, 1'b0, 1'b0);
    wait_an(1'b0);
  endtask : pd
  task automatic do_reset(input logic an, input logic [3:0] ab);
    presetn     <= 1'b0;
    strap_an_en <= an;
    strap_adv   <= ab;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset

  // ==========================================
  // Scenarios
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {num_errors, num_checks, cyc} = '0;
    do_reset(1'b1, 4'hF);
    rdchk("bmc_an", `PAC_OFF_BMC, 32'h1000, 32'h1000);
    rdchk("adv", `PAC_OFF_ADV, 32'h01E1, 32'hFFFFFFFF);
    rdchk("bms", `PAC_OFF_BMS, 32'h7849, 32'hFFFFFFFF);
    apb(1'b0, 8'h00, 32'h0);
    chk("unmapped_err", 32'h1, 32'(er));
    chk("pready", 32'h1, 32'(pready));
    chk("flp_en", 32'h1, 32'(tx_flp_en));
    apb(1'b1, `PAC_OFF_ADV, 32'h0060);
    rdchk("adv_10", `PAC_OFF_ADV, 32'h0061, 32'hFFFFFFFF);
    chk("code_word", 32'h0061, 32'(tx_code_word));
    // Link must stand when negotiation ends, or it counts as lost
    lp.set_link(1'b1, 1'b0, 1'b1);
    lp.send(16'h01E1, 6);
    wait_an(1'b1);
    chk("mode_10f", 32'h3, 32'(mode));
    rdchk("sts_10f", `PAC_OFF_STS, 32'h0014, 32'h0016);
    rdchk("lpa", `PAC_OFF_LPA, 32'h01E1, 32'hFFFFFFFF);
    rdchk("exp_pg", `PAC_OFF_EXP, 32'h0007, 32'h001F);
    rdchk("exp_clr", `PAC_OFF_EXP, 32'h0005, 32'h001F);
    rdchk("bms_done", `PAC_OFF_BMS, 32'h0024, 32'h0024);
    lp.set_link(1'b1, 1'b0, 1'b1);
    repeat (6) @(posedge pclk);
    rdchk("bms_link", `PAC_OFF_BMS, 32'h0024, 32'h0024);
    lp.set_link(1'b1, 1'b0, 1'b0);
    wait_an(1'b0);
    chk("flp_again", 32'h1, 32'(tx_flp_en));
    // Base page with remote fault and next pages
    apb(1'b1, `PAC_OFF_ADV, 32'h01E0);
    lp.set_link(1'b1, 1'b1, 1'b0);
    lp.send(16'hA1E1, 2);
    rdchk("lpa_base", `PAC_OFF_LPA, 32'hA1E1, 32'hFFFFFFFF);
    chk("np_pending", 32'h0, 32'(an_complete));
    lp.send(16'h8123, 0);
    rdchk("lpa_np", `PAC_OFF_LPA, 32'h8123, 32'hFFFFFFFF);
    lp.send(16'h0456, 1);
    wait_an(1'b1);
    rdchk("lpa_last", `PAC_OFF_LPA, 32'h0456, 32'hFFFFFFFF);
    chk("mode_100f", 32'h7, 32'(mode));
    rdchk("exp_np", `PAC_OFF_EXP, 32'h000F, 32'h001F);
    rdchk("bms_rf", `PAC_OFF_BMS, 32'h0030, 32'h0030);
    // Restart holds everything quiet for the break time
    apb(1'b1, `PAC_OFF_BMC, 32'h1200);
    n = 0;
    for (k = 0; k < 100; k++) begin
      @(posedge pclk);
      if (tx_halt === 1'b1) begin
        n++;
        if (n == 1) chk("halt_quiet", 32'h0, 32'(tx_flp_en));
      end else if (n > 0) begin
        break;
      end
    end
    chk("halt_len", 32'd20, 32'(n));
    chk("flp_resume", 32'h1, 32'(tx_flp_en));
    rdchk("bmc_selfclr", `PAC_OFF_BMC, 32'h0, 32'h0200);
    pd(1'b1, 1'b0, 32'h0081, 3'b101);
    pd(1'b0, 1'b1, 32'h0021, 3'b001);
    lp.set_link(1'b0, 1'b1, 1'b1);
    repeat (6) @(posedge pclk);
    rdchk("pd_fault", `PAC_OFF_EXP, 32'h0010, 32'h0010);
    chk("pd_none", 32'h0, 32'(an_complete));
    lp.set_link(1'b1, 1'b0, 1'b1);
    // Forced modes, then enable again
    apb(1'b1, `PAC_OFF_BMC, 32'h2100);
    rdchk("sts_100f", `PAC_OFF_STS, 32'h0006, 32'h0006);
    chk("forced_100f", 32'h7, 32'(mode));
    chk("forced_quiet", 32'h0, 32'(tx_flp_en));
    apb(1'b1, `PAC_OFF_BMC, 32'h0000);
    rdchk("sts_10h", `PAC_OFF_STS, 32'h0000, 32'h0006);
    chk("forced_10h", 32'h1, 32'(mode));
    apb(1'b1, `PAC_OFF_BMC, 32'h1000);
    apb(1'b1, `PAC_OFF_BMC, 32'h3100);
    chk("enabled_flp", 32'h1, 32'(tx_flp_en));
    lp.send(16'h0021, 1);
    wait_an(1'b1);
    chk("an_ignores", 32'h1, 32'(mode));
    // 10 Mb/s link lost, partner now offers everything at 100 Mb/s
    lp.set_link(1'b1, 1'b1, 1'b0);
    wait_an(1'b0);
    lp.send(16'h01E1, 1);
    wait_an(1'b1);
    chk("mode_top", 32'h7, 32'(mode));
    // Straps chosen differently at the next power-up
    do_reset(1'b0, 4'h3);
    rdchk("adv_strap", `PAC_OFF_ADV, 32'h0061, 32'hFFFFFFFF);
    rdchk("bmc_strap", `PAC_OFF_BMC, 32'h0, 32'h1000);
    chk("strap_quiet", 32'h0, 32'(tx_flp_en));
    close_out();
  end
endmodule : pac_autoneg_test

// file: verification/pac_partner.sv
// Far-end link partner model: code words and link detect levels.
// Assumes the device clock; every change lands just after a rising edge.
`timescale 1ns/1ns
module pac_partner (
  input  wire logic        pclk,        // Device clock
  input  wire logic        tx_flp_en,   // Device sending bursts
  output logic             flp_seen,    // Partner bursts present
  output logic             page_in,     // Code word strobe
  output logic      [15:0] page_word,   // Code word
  output logic             link100_raw, // 100 Mb/s link level
  output logic             link10_raw   // 10 Mb/s link level
);
  initial begin
    flp_seen    = 1'b1;
    page_in     = 1'b0;
    page_word   = 16'hFFFF;
    link100_raw = 1'b0;
    link10_raw  = 1'b0;
  end
  // ==========================================
  // Code word exchange
  task automatic send(input logic [15:0] w, input int gap);
    int n;
    n = 0;
    repeat (gap) @(posedge pclk);
    // Wait for the device to burst, at most 200 cycles, then answer
    while (tx_flp_en !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    page_in   <= 1'b1;
    page_word <= w;
    @(posedge pclk);
    page_in   <= 1'b0;
    // Stale word inverted so it never passes for valid
    page_word <= ~w;
  endtask : send
  task automatic set_link(input logic an, input logic l100,
                          input logic l10);
    @(posedge pclk);
    flp_seen    <= an;
    link100_raw <= l100;
    link10_raw  <= l10;
  endtask : set_link
endmodule : pac_partner
